// File: logic/ufesr_map.svh
// Register offsets, field positions and reset values of the endpoint bank
`ifndef UFESR_MAP_SVH
`define UFESR_MAP_SVH
`define UFESR_A_RX_STAT 5'h12
`define UFESR_A_RX_MPS 5'h13
`define UFESR_A_TX_DATA 5'h14
`define UFESR_A_TX_CNT 5'h15
`define UFESR_A_TX_STAT 5'h16
`define UFESR_A_TX_MPS 5'h17
`define UFESR_A_REV 5'h18
`define UFESR_A_HS_STAT 5'h19
`define UFESR_A_FRM_HI 5'h1a
`define UFESR_A_FRM_LO 5'h1b
`define UFESR_A_EXT_SEL 5'h1c
`define UFESR_A_EXT_WIN 5'h1d
`define UFESR_X_VID_HI 8'h00
`define UFESR_X_VID_LO 8'h01
`define UFESR_X_PID_HI 8'h02
`define UFESR_X_PID_LO 8'h03
`define UFESR_X_REL_HI 8'h04
`define UFESR_X_REL_LO 8'h05
`define UFESR_X_RX_AF 8'h06
`define UFESR_X_TX_AE 8'h07
`define UFESR_X_STR 8'h08
`define UFESR_X_PWR 8'h09
`define UFESR_X_TOG 8'h0a
`define UFESR_X_FCTL 8'h0c
`define UFESR_MPS_RST 8'h08
`define UFESR_AF_RST 6'h3c
`define UFESR_AE_RST 6'h04
`define UFESR_PWR_RST 8'hfa
`define UFESR_B_VALID 5
`define UFESR_B_FLUSH 4
`define UFESR_B_OVF 3
`define UFESR_B_UNF 2
`define UFESR_B_FULL 1
`define UFESR_B_EMPTY 0
`define UFESR_B_SUSP 7
`define UFESR_B_MBOX 0
`define UFESR_TOG_MASK 8'hfd
`endif

// File: logic/ufesr_pkg.sv
// Types shared by the endpoint status register bank
package ufesr_pkg;
  // One-cycle event pulses from the serial engine
  typedef struct packed {
    logic tx_pop;
    logic in_ack;
    logic in_nak;
    logic in_stall;
    logic out_ack;
    logic out_nak;
    logic out_stall;
    logic suspend_req;
    logic sof;
    logic mbox_written;
    logic mbox_read;
    logic rx_push;
    logic [3:0] xfer_done;
  } ufesr_ev_t;
  // Descriptor fields handed to the request decoder
  typedef struct packed {
    logic [15:0] vendor;
    logic [15:0] product;
    logic [15:0] release_num;
    logic [7:0] rx_mps;
    logic [7:0] tx_mps;
    logic [7:0] max_current;
    logic [7:0] str_mfr_idx;
    logic [7:0] str_prod_idx;
    logic str_stall;
  } ufesr_desc_t;
endpackage

// File: logic/ufesr_regs.sv
// Endpoint FIFO, handshake status and extended register bank
`include "ufesr_map.svh"
module ufesr_regs
  import ufesr_pkg::*;
#(
  parameter int DEPTH = 64,
  parameter logic [7:0] REVISION = 8'h01, // Arbitrary value
  parameter logic [15:0] VID_RST = 16'h1234, // Arbitrary value
  parameter logic [15:0] PID_RST = 16'h5678, // Arbitrary value
  parameter logic [15:0] REL_RST = 16'h0100 // Arbitrary value
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic reset_in,
  // Local byte bus
  input wire logic [4:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  // Serial engine side
  input wire ufesr_ev_t ev_in,
  input wire logic [10:0] frame_in,
  input wire logic [6:0] rx_count_in,
  output logic [7:0] tx_data_out,
  output logic tx_send_ok_out,
  output logic tx_empty_out,
  output logic suspend_enter_out,
  output logic [3:0] toggle_out,
  output ufesr_desc_t desc_out,
  // Threshold status
  input wire logic [1:0] almost_clr_in,
  output logic [1:0] almost_out
);
  localparam int PW = $clog2(DEPTH);

  // Depth must fit the seven-bit count and the pointer wrap
  if (DEPTH < 2 || DEPTH > 64 || (1 << PW) != DEPTH) begin : g_bad_depth
    $error("DEPTH must be a power of two from 2 to 64");
  end

  // Bus write decode
  function automatic logic wr_at(input logic [4:0] a);
    return wr_in && (addr_in == a);
  endfunction

  // Write-one-to-clear with set winning
  function automatic logic sticky(input logic q, input logic set,
                                  input logic clr);
    return set | (q & ~clr);
  endfunction

  logic [7:0] mem [DEPTH];
  logic [PW-1:0] wp_q;
  logic [PW-1:0] rp_q;
  logic [6:0] cnt_q;
  logic tx_full;
  logic tx_empty;
  logic push;
  logic pop;
  logic flush;
  logic valid_q;
  logic ovf_q;
  logic unf_q;
  logic [7:0] rx_mps_q;
  logic [7:0] tx_mps_q;
  logic [7:0] hs_q;
  logic [10:0] frame_q;
  logic [7:0] sel_q;
  logic [15:0] vid_q;
  logic [15:0] pid_q;
  logic [15:0] rel_q;
  logic [5:0] af_q;
  logic [5:0] ae_q;
  logic str_en_q;
  logic [7:0] pwr_q;
  logic [7:0] tog_q;
  logic vmode_q;
  logic susp_q;
  logic [1:0] alm_q;
  logic [7:0] rd_q;
  logic [7:0] txd_q;
  logic [7:0] ext_rd;
  logic [7:0] rd_mux;
  logic ext_wr;
  logic [7:0] hs_set;
  logic [7:0] hs_clr;

  assign tx_full = (cnt_q == 7'(DEPTH));
  assign tx_empty = (cnt_q == 7'd0);
  assign push = wr_at(`UFESR_A_TX_DATA) && !tx_full;
  assign flush = wr_at(`UFESR_A_TX_STAT) && wdata_in[`UFESR_B_FLUSH];
  assign pop = ev_in.tx_pop && !tx_empty && !flush;
  assign ext_wr = wr_at(`UFESR_A_EXT_WIN);

  // FIFO storage
  always_ff @(posedge mclk_in) begin
    if (push) begin
      mem[wp_q] <= wdata_in;
    end
  end

  // Pointers and count
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= 7'h00;
    end else if (flush) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= 7'h00;
    end else begin
      if (push) begin
        wp_q <= wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= rp_q + 1'b1;
      end
      cnt_q <= cnt_q + 7'(push) - 7'(pop);
    end
  end

  // Byte handed to the engine
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      txd_q <= 8'h00;
    end else if (pop) begin
      txd_q <= mem[rp_q];
    end
  end

  // Transmit error and valid flags
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      ovf_q <= 1'b0;
      unf_q <= 1'b0;
      valid_q <= 1'b0;
    end else begin
      ovf_q <= sticky(ovf_q, wr_at(`UFESR_A_TX_DATA) && tx_full,
                      flush ? 1'b0 : wr_at(`UFESR_A_TX_STAT) &&
                      wdata_in[`UFESR_B_OVF]);
      unf_q <= sticky(unf_q, ev_in.tx_pop && tx_empty,
                      wr_at(`UFESR_A_TX_STAT) && wdata_in[`UFESR_B_UNF]);
      // Written by CPU, host read clears
      if (wr_at(`UFESR_A_TX_STAT)) begin
        valid_q <= wdata_in[`UFESR_B_VALID];
      end else if (ev_in.tx_pop) begin
        valid_q <= 1'b0;
      end
    end
  end

  // NAK unless valid in valid mode
  assign tx_send_ok_out = !tx_empty && (!vmode_q || valid_q);
  assign tx_empty_out = tx_empty;
  assign tx_data_out = txd_q;

  // Handshake event sets and bus clears
  always_comb begin
    hs_set = 8'h00;
    hs_set[7] = ev_in.suspend_req;
    hs_set[6] = ev_in.in_stall;
    hs_set[5] = ev_in.in_nak;
    hs_set[4] = ev_in.in_ack;
    hs_set[3] = ev_in.out_stall;
    hs_set[2] = ev_in.out_nak;
    hs_set[1] = ev_in.out_ack;
    hs_set[0] = ev_in.mbox_written;
    hs_clr = wr_at(`UFESR_A_HS_STAT) ? wdata_in : 8'h00;
  end

  // Handshake status register
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      hs_q <= 8'h00;
    end else begin
      for (int i = 1; i < 8; i++) begin
        hs_q[i] <= sticky(hs_q[i], hs_set[i], hs_clr[i]);
      end
      if (hs_set[0]) begin
        hs_q[0] <= 1'b1;
      end else if (ev_in.mbox_read) begin
        hs_q[0] <= 1'b0;
      end else if (wr_at(`UFESR_A_HS_STAT)) begin
        hs_q[0] <= wdata_in[`UFESR_B_MBOX];
      end
    end
  end

  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      susp_q <= 1'b0;
    end else begin
      susp_q <= hs_clr[`UFESR_B_SUSP];
    end
  end
  assign suspend_enter_out = susp_q;

  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      frame_q <= 11'h000;
    end else if (ev_in.sof) begin
      frame_q <= frame_in;
    end
  end

  // Directly addressed writable registers
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      rx_mps_q <= `UFESR_MPS_RST;
      tx_mps_q <= `UFESR_MPS_RST;
      sel_q <= 8'h00;
    end else begin
      if (wr_at(`UFESR_A_RX_MPS)) begin
        rx_mps_q <= wdata_in;
      end
      if (wr_at(`UFESR_A_TX_MPS)) begin
        tx_mps_q <= wdata_in;
      end
      if (wr_at(`UFESR_A_EXT_SEL)) begin
        sel_q <= wdata_in;
      end
    end
  end

  // Extended registers written through the window
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      vid_q <= VID_RST;
      pid_q <= PID_RST;
      rel_q <= REL_RST;
      af_q <= `UFESR_AF_RST;
      ae_q <= `UFESR_AE_RST;
      str_en_q <= 1'b1;
      pwr_q <= `UFESR_PWR_RST;
      vmode_q <= 1'b0;
    end else if (ext_wr) begin
      unique case (sel_q)
        `UFESR_X_VID_HI: vid_q[15:8] <= wdata_in;
        `UFESR_X_VID_LO: vid_q[7:0] <= wdata_in;
        `UFESR_X_PID_HI: pid_q[15:8] <= wdata_in;
        `UFESR_X_PID_LO: pid_q[7:0] <= wdata_in;
        `UFESR_X_REL_HI: rel_q[15:8] <= wdata_in;
        `UFESR_X_REL_LO: rel_q[7:0] <= wdata_in;
        `UFESR_X_RX_AF: af_q <= wdata_in[5:0];
        `UFESR_X_TX_AE: ae_q <= wdata_in[5:0];
        `UFESR_X_STR: str_en_q <= wdata_in[0];
        `UFESR_X_PWR: pwr_q <= wdata_in;
        `UFESR_X_FCTL: vmode_q <= wdata_in[0];
        default: begin
        end
      endcase
    end
  end

  // Data toggle bits and modes
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      tog_q <= 8'h00;
    end else if (ext_wr && sel_q == `UFESR_X_TOG) begin
      tog_q <= wdata_in & `UFESR_TOG_MASK;
    end else begin
      if (ev_in.xfer_done[3]) begin
        tog_q[7] <= tog_q[3] ? 1'b0 : ~tog_q[7];
      end
      if (ev_in.xfer_done[2]) begin
        tog_q[6] <= tog_q[2] ? 1'b0 : ~tog_q[6];
      end
      if (ev_in.xfer_done[1]) begin
        tog_q[5] <= ~tog_q[5];
      end
      if (ev_in.xfer_done[0]) begin
        tog_q[4] <= tog_q[0] ? 1'b0 : ~tog_q[4];
      end
    end
  end
  assign toggle_out = tog_q[7:4];

  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      alm_q <= 2'b00;
    end else begin
      alm_q[0] <= sticky(alm_q[0],
                         ev_in.rx_push && rx_count_in == {1'b0, af_q},
                         almost_clr_in[0]);
      alm_q[1] <= sticky(alm_q[1], pop && cnt_q == {1'b0, ae_q},
                         almost_clr_in[1]);
    end
  end
  assign almost_out = alm_q;

  // Extended window read mux
  always_comb begin
    unique case (sel_q)
      `UFESR_X_VID_HI: ext_rd = vid_q[15:8];
      `UFESR_X_VID_LO: ext_rd = vid_q[7:0];
      `UFESR_X_PID_HI: ext_rd = pid_q[15:8];
      `UFESR_X_PID_LO: ext_rd = pid_q[7:0];
      `UFESR_X_REL_HI: ext_rd = rel_q[15:8];
      `UFESR_X_REL_LO: ext_rd = rel_q[7:0];
      `UFESR_X_RX_AF: ext_rd = {2'b00, af_q};
      `UFESR_X_TX_AE: ext_rd = {2'b00, ae_q};
      `UFESR_X_STR: ext_rd = {7'h00, str_en_q};
      `UFESR_X_PWR: ext_rd = pwr_q;
      `UFESR_X_TOG: ext_rd = tog_q;
      `UFESR_X_FCTL: ext_rd = {7'h00, vmode_q};
      default: ext_rd = 8'h00;
    endcase
  end

  // Register read mux, reserved bits zero
  always_comb begin
    unique case (addr_in)
      `UFESR_A_RX_STAT: rd_mux = {6'h00, rx_count_in == 7'(DEPTH),
                                  rx_count_in == 7'h00};
      `UFESR_A_RX_MPS: rd_mux = rx_mps_q;
      `UFESR_A_TX_CNT: rd_mux = {1'b0, cnt_q};
      `UFESR_A_TX_STAT: rd_mux = {2'b00, valid_q, 1'b0, ovf_q, unf_q,
                                  tx_full, tx_empty};
      `UFESR_A_TX_MPS: rd_mux = tx_mps_q;
      `UFESR_A_REV: rd_mux = REVISION;
      `UFESR_A_HS_STAT: rd_mux = hs_q;
      `UFESR_A_FRM_HI: rd_mux = {5'h00, frame_q[10:8]};
      `UFESR_A_FRM_LO: rd_mux = frame_q[7:0];
      `UFESR_A_EXT_SEL: rd_mux = sel_q;
      `UFESR_A_EXT_WIN: rd_mux = ext_rd;
      default: rd_mux = 8'h00;
    endcase
  end

  // Read data captured on strobe
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      rd_q <= 8'h00;
    end else if (rd_in) begin
      rd_q <= rd_mux;
    end
  end
  assign rdata_out = rd_q;

  // Descriptor fields
  always_comb begin
    desc_out.vendor = vid_q;
    desc_out.product = pid_q;
    desc_out.release_num = rel_q;
    desc_out.rx_mps = rx_mps_q;
    desc_out.tx_mps = tx_mps_q;
    desc_out.max_current = pwr_q;
    desc_out.str_mfr_idx = str_en_q ? 8'h01 : 8'h00;
    desc_out.str_prod_idx = str_en_q ? 8'h02 : 8'h00;
    desc_out.str_stall = !str_en_q;
  end
endmodule // ufesr_regs

// File: test/ufesr_regs_properties.sv
// Port-level assertion checker for the endpoint register bank
module ufesr_regs_properties
  import ufesr_pkg::*;
#(
  parameter int DEPTH = 64
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic reset_in,
  // Local byte bus
  input wire logic [4:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [7:0] rdata_out,
  // Serial engine side
  input wire ufesr_ev_t ev_in,
  input wire logic [10:0] frame_in,
  input wire logic [6:0] rx_count_in,
  input wire logic [7:0] tx_data_out,
  input wire logic tx_send_ok_out,
  input wire logic tx_empty_out,
  input wire logic suspend_enter_out,
  input wire logic [3:0] toggle_out,
  input wire ufesr_desc_t desc_out,
  // Threshold status
  input wire logic [1:0] almost_clr_in,
  input wire logic [1:0] almost_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (reset_in);
  // Bus and engine steps that start multi-cycle checks
  sequence s_susp_wr;
    wr_in && addr_in == 5'h19 && wdata_in[7];
  endsequence
  // Marker, one quiet cycle, then a read of the low frame byte
  sequence s_frm_rd;
    ev_in.sof ##1 !ev_in.sof ##1 (rd_in && addr_in == 5'h1b);
  endsequence
  property p_push;
    wr_in && addr_in == 5'h14 |=> !tx_empty_out;
  endproperty
  property p_flush;
    wr_in && addr_in == 5'h16 && wdata_in[4] |=> tx_empty_out && !tx_send_ok_out;
  endproperty
  property p_susp_go;
    s_susp_wr |=> suspend_enter_out;
  endproperty
  property p_susp_why;
    suspend_enter_out |-> $past(wr_in && addr_in == 5'h19 && wdata_in[7]);
  endproperty
  property p_send_ok;
    tx_send_ok_out |-> !tx_empty_out;
  endproperty
  property p_frame;
    s_frm_rd |=> rdata_out == $past(frame_in[7:0], 3);
  endproperty
  property p_str;
    desc_out.str_mfr_idx == (desc_out.str_stall ? 8'h00 : 8'h01) &&
      desc_out.str_prod_idx == (desc_out.str_stall ? 8'h00 : 8'h02);
  endproperty
  property p_pwr;
    $changed(desc_out.max_current) |-> $past(wr_in && addr_in == 5'h1d) ||
      $past(wr_in && addr_in == 5'h1d, 2);
  endproperty
  property p_rst_empty;
    $fell(reset_in) |-> tx_empty_out;
  endproperty
  a_push: assert property (p_push)
    else $error("push left fifo empty");
  a_flush: assert property (p_flush)
    else $error("flush did not empty fifo");
  a_susp_go: assert property (p_susp_go)
    else $error("no suspend pulse");
  a_susp_why: assert property (p_susp_why)
    else $error("suspend pulse without write");
  a_send_ok: assert property (p_send_ok)
    else $error("send allowed while empty");
  a_frame: assert property (p_frame)
    else $error("frame low byte wrong");
  a_str: assert property (p_str)
    else $error("string index mismatch");
  a_pwr: assert property (p_pwr)
    else $error("max current changed alone");
  a_rst_empty: assert property (p_rst_empty)
    else $error("fifo not empty after reset");
endmodule // ufesr_regs_properties

bind ufesr_regs ufesr_regs_properties #(.DEPTH(DEPTH)) u_props (
  .mclk_in(mclk_in), .reset_in(reset_in), .addr_in(addr_in),
  .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
  .ev_in(ev_in), .frame_in(frame_in), .rx_count_in(rx_count_in),
  .tx_data_out(tx_data_out), .tx_send_ok_out(tx_send_ok_out),
  .tx_empty_out(tx_empty_out), .suspend_enter_out(suspend_enter_out),
  .toggle_out(toggle_out), .desc_out(desc_out),
  .almost_clr_in(almost_clr_in), .almost_out(almost_out));

// File: test/ufesr_engine_model.sv
// Serial engine stand-in that raises event pulses and drains bytes
module ufesr_engine_model
  import ufesr_pkg::*;
(
  // Clock
  input wire logic mclk_in,
  // Towards the register bank
  output ufesr_ev_t ev_out,
  output logic [10:0] frame_out,
  input wire logic [7:0] tx_data_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle state at time zero
  initial begin
    ev_out = '0;
    frame_out = 11'h000;
  end
  task automatic pulse(input ufesr_ev_t e);
    @(negedge mclk_in);
    ev_out = e;
    @(negedge mclk_in);
    ev_out = '0;
  endtask
  // Frame number only valid with the marker, inverted afterwards
  task automatic sof(input logic [10:0] f);
    @(negedge mclk_in);
    frame_out = f;
    ev_out.sof = 1'b1;
    @(negedge mclk_in);
    ev_out = '0;
    frame_out = ~f;
  endtask
  task automatic host_pop(output logic [7:0] b);
    pulse(16'h8000);
    b = tx_data_in;
  endtask
endmodule // ufesr_engine_model

// File: test/test_ufesr_regs.sv
// Self-checking bench for the endpoint register bank
module test_ufesr_regs
  import ufesr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] REV = 8'h5a; // Arbitrary value
  logic mclk_in = 1'b0;
  logic reset_in;
  logic [4:0] addr_in;
  logic [7:0] wdata_in;
  logic wr_in;
  logic rd_in;
  logic [6:0] rx_count_in;
  logic [1:0] almost_clr_in;
  logic [7:0] rdata_out, tx_data_out, b;
  logic tx_send_ok_out, tx_empty_out, suspend_enter_out;
  logic [3:0] toggle_out;
  logic [1:0] almost_out;
  logic [10:0] frame_in;
  ufesr_ev_t ev_in;
  ufesr_desc_t desc_out;
  int fails = 0;
  int checks_done = 0;
  logic [4:0] ra [11] = '{5'h12, 5'h13, 5'h15, 5'h16, 5'h17, 5'h18, 5'h19,
    5'h1a, 5'h1b, 5'h1c, 5'h1e};
  logic [7:0] rv [11] = '{8'h01, 8'h08, 8'h00, 8'h01, 8'h08, REV, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0] xi [6] = '{8'h06, 8'h07, 8'h08, 8'h09, 8'h0a, 8'h0c};
  logic [7:0] xv [6] = '{8'h3c, 8'h04, 8'h01, 8'hfa, 8'h00, 8'h00};
  logic [15:0] hs [8] = '{16'h0040, 16'h0800, 16'h0400, 16'h0200,
    16'h4000, 16'h2000, 16'h1000, 16'h0100};
  // Clock
  always #2.5 mclk_in = ~mclk_in;
  // Design and engine stand-in
  ufesr_regs #(.REVISION(REV)) u_ufesr_regs (.mclk_in(mclk_in),
    .reset_in(reset_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .ev_in(ev_in),
    .frame_in(frame_in), .rx_count_in(rx_count_in),
    .tx_data_out(tx_data_out), .tx_send_ok_out(tx_send_ok_out),
    .tx_empty_out(tx_empty_out), .suspend_enter_out(suspend_enter_out),
    .toggle_out(toggle_out), .desc_out(desc_out),
    .almost_clr_in(almost_clr_in), .almost_out(almost_out));
  ufesr_engine_model u_ufesr_engine_model (.mclk_in(mclk_in),
    .ev_out(ev_in), .frame_out(frame_in), .tx_data_in(tx_data_out));
  // Comparison and bus tasks
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(negedge mclk_in);
    addr_in = a;
    wdata_in = d;
    wr_in = 1'b1;
    @(negedge mclk_in);
    wr_in = 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, input logic [7:0] exp);
    @(negedge mclk_in);
    addr_in = a;
    rd_in = 1'b1;
    @(negedge mclk_in);
    rd_in = 1'b0;
    @(negedge mclk_in);
    chk(rdata_out, exp);
  endtask
  task automatic xwr(input logic [7:0] i, input logic [7:0] d);
    wr(5'h1c, i);
    wr(5'h1d, d);
  endtask
  task automatic xrd(input logic [7:0] i, input logic [7:0] exp);
    wr(5'h1c, i);
    rd(5'h1d, exp);
  endtask
  task automatic clr_almost(input logic [1:0] m);
    @(negedge mclk_in);
    almost_clr_in = m;
    @(negedge mclk_in);
    almost_clr_in = 2'h0;
    chk(8'(almost_out), 8'h00);
  endtask
  task automatic print_verdict;
    $display("checks %0d failures %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Watchdog against a hang
  initial begin
    #200us;
    fails++;
    print_verdict;
  end
  // Main sequence
  initial begin
    reset_in = 1'b1;
    addr_in = 5'h00;
    wdata_in = 8'h00;
    wr_in = 1'b0;
    rd_in = 1'b0;
    rx_count_in = 7'h00;
    almost_clr_in = 2'h0;
    repeat (3) @(posedge mclk_in);
    @(negedge mclk_in);
    reset_in = 1'b0;
    foreach (ra[i]) rd(ra[i], rv[i]);
    foreach (xi[i]) xrd(xi[i], xv[i]);
    chk(desc_out.product[15:8], 8'h56);
    wr(5'h13, 8'h10);
    rd(5'h13, 8'h10);
    chk(desc_out.rx_mps, 8'h10);
    wr(5'h18, 8'hff);
    rd(5'h18, REV);
    wr(5'h16, 8'hc0);
    rd(5'h16, 8'h01);
    // Fill until full, then overflow
    for (int i = 0; i < 64; i++) wr(5'h14, 8'h40 + 8'(i));
    rd(5'h15, 8'h40);
    rd(5'h16, 8'h02);
    wr(5'h14, 8'hee);
    rd(5'h16, 8'h0a);
    wr(5'h16, 8'h08);
    rd(5'h16, 8'h02);
    u_ufesr_engine_model.host_pop(b);
    chk(b, 8'h40);
    rd(5'h15, 8'h3f);
    // Valid mode gating
    xwr(8'h0c, 8'h01);
    chk(8'(tx_send_ok_out), 8'h00);
    wr(5'h16, 8'h20);
    rd(5'h16, 8'h20);
    chk(8'(tx_send_ok_out), 8'h01);
    u_ufesr_engine_model.host_pop(b);
    chk(b, 8'h41);
    rd(5'h16, 8'h00);
    chk(8'(tx_send_ok_out), 8'h00);
    xwr(8'h0c, 8'h00);
    // Flush, then pop while empty
    wr(5'h16, 8'h10);
    rd(5'h16, 8'h01);
    rd(5'h15, 8'h00);
    chk(8'(tx_empty_out), 8'h01);
    u_ufesr_engine_model.host_pop(b);
    rd(5'h16, 8'h05);
    wr(5'h16, 8'h04);
    rd(5'h16, 8'h01);
    // Threshold crossings on both sides
    repeat (4) wr(5'h14, 8'h11);
    u_ufesr_engine_model.host_pop(b);
    chk(8'(almost_out), 8'h02);
    clr_almost(2'h2);
    rx_count_in = 7'h3c;
    u_ufesr_engine_model.pulse(16'h0010);
    chk(8'(almost_out), 8'h01);
    clr_almost(2'h1);
    rx_count_in = 7'h40;
    rd(5'h12, 8'h02);
    wr(5'h16, 8'h10);
    // Handshake flags raised and cleared one by one
    for (int i = 0; i < 8; i++) begin
      u_ufesr_engine_model.pulse(hs[i]);
      rd(5'h19, 8'h01 << i);
      if (i == 0) u_ufesr_engine_model.pulse(16'h0020);
      else wr(5'h19, 8'h01 << i);
      chk(8'(suspend_enter_out), 8'(i == 7));
      rd(5'h19, 8'h00);
    end
    // Low byte read first so the frame property sees the marker
    u_ufesr_engine_model.sof(11'h5a3);
    rd(5'h1b, 8'ha3);
    rd(5'h1a, 8'h05);
    // Indexed access and descriptor fields
    xwr(8'h00, 8'hab);
    rd(5'h1d, 8'hab);
    rd(5'h1d, 8'hab);
    rd(5'h1c, 8'h00);
    chk(desc_out.vendor[15:8], 8'hab);
    xwr(8'h05, 8'h77);
    xwr(8'h08, 8'h00);
    xwr(8'h09, 8'h64);
    xwr(8'h06, 8'hff);
    rd(5'h1d, 8'h3f);
    chk(desc_out.release_num[7:0], 8'h77);
    chk(8'(desc_out.str_stall), 8'h01);
    chk(desc_out.str_mfr_idx, 8'h00);
    chk(desc_out.max_current, 8'h64);
    // Toggle behaviour per mode
    xwr(8'h0a, 8'h00);
    u_ufesr_engine_model.pulse(16'h0008);
    xrd(8'h0a, 8'h80);
    u_ufesr_engine_model.pulse(16'h0008);
    rd(5'h1d, 8'h00);
    xwr(8'h0a, 8'hff);
    rd(5'h1d, 8'hfd);
    chk(8'(toggle_out), 8'h0f);
    u_ufesr_engine_model.pulse(16'h0009);
    rd(5'h1d, 8'h6d);
    u_ufesr_engine_model.pulse(16'h0004);
    rd(5'h1d, 8'h2d);
    u_ufesr_engine_model.pulse(16'h0002);
    rd(5'h1d, 8'h0d);
    print_verdict;
  end
endmodule // test_ufesr_regs
